/* File: mop_top.sv */
// motor overload protection: thermal model, jam, short-circuit, loss-of-load
//
// Function
// - class set point is trip seconds at six times full-load current, 1 s steps
// - twenty-six service factors 100..125 percent with forty-five classes
// - ultimate current is full-load current times service factor
// - accumulator moves exponentially toward a current-dependent final value
// - time constant comes from service factor and class
// - below ultimate current the accumulator settles under full level
// - thermal model is fed the largest phase current
// - thermal trip when accumulator reaches full level
// - thermal trip cannot clear until accumulator is at most thirty percent
// - autoreset clears thermal trip itself at thirty percent
// - thermal alarm when accumulator at or above alarm over trip class ratio
// - deleted thermal trip also disables thermal alarm
// - running after current held within 10..125 percent for over ten seconds
// - jam trip and alarm only evaluated while running
// - optional instantaneous short-circuit trip at twelve times full-load current
// - short-circuit trip works with jam trip deleted
// - loss-of-load protection only evaluated while running
// - loss-of-load alarm or trip when current falls below set point
// - delete code in a set point disables that function
// - alarms self-clear unless latching; trips latch until reset, except the thermal trip, which autoreset also clears
`timescale 1ns/1ns
module mop_top
  import mop_pkg::*;
#(
  parameter int TICK_CYCLES = mop_pkg::TICK_CYC
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [mop_pkg::CUR_W-1:0] phase_a_i,
  input wire logic [mop_pkg::CUR_W-1:0] phase_b_i,
  input wire logic [mop_pkg::CUR_W-1:0] phase_c_i,
  input wire logic [mop_pkg::CUR_W-1:0] full_load_current_i,
  input wire logic [mop_pkg::SF_W-1:0] sf_code_i,
  input wire logic [mop_pkg::CLS_W-1:0] class_trip_i,
  input wire logic [mop_pkg::CLS_W-1:0] class_alarm_i,
  input wire logic [mop_pkg::SP_W-1:0] oc_trip_sp_i,
  input wire logic [mop_pkg::SP_W-1:0] oc_alarm_sp_i,
  input wire logic [mop_pkg::SP_W-1:0] uc_trip_sp_i,
  input wire logic [mop_pkg::SP_W-1:0] uc_alarm_sp_i,
  input wire logic sc_en_i,
  input wire logic autoreset_i,
  input wire logic alarm_latch_i,
  input wire logic reset_btn_i,
  output logic [mop_pkg::ACC_W-1:0] thermal_accumulator_o,
  output logic thermal_trip_o,
  output logic thermal_alarm_o,
  output logic oc_trip_o,
  output logic oc_alarm_o,
  output logic sc_trip_o,
  output logic uc_trip_o,
  output logic uc_alarm_o,
  output logic running_o
);

  import mop_pkg::*;

  // ****************************************************
  // helpers
  // ****************************************************
  function automatic logic is_del(input logic [SP_W-1:0] sp);
    return sp == SP_DEL;
  endfunction

  // cur >= fla * pct / 100, done without a divider
  function automatic logic pct_ge(input logic [CUR_W-1:0] cur,
                                  input logic [CUR_W-1:0] full_load_current,
                                  input logic [SP_W-1:0] pct);
    return (32'(cur) * 32'd100) >= (32'(full_load_current) * 32'(pct));
  endfunction

  function automatic logic [CUR_W-1:0] max3(input logic [CUR_W-1:0] a,
                                            input logic [CUR_W-1:0] b,
                                            input logic [CUR_W-1:0] c);
    logic [CUR_W-1:0] m;
    m = (a > b) ? a : b;
    return (m > c) ? m : c;
  endfunction

  // ****************************************************
  // tick and reset button
  // ****************************************************
  logic tick;

  mop_tick #(
    .CYC(TICK_CYCLES)
  ) u_tick (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .tick_o(tick)
  );

  // the button is a pin, so it passes two flops first
  logic btn_meta_ff;
  logic btn_sync_ff;

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      btn_meta_ff <= 1'b0;
      btn_sync_ff <= 1'b0;
    end
    else
    begin
      btn_meta_ff <= reset_btn_i;
      btn_sync_ff <= btn_meta_ff;
    end
  end

  logic reset_req;
  assign reset_req = btn_sync_ff;

  // ****************************************************
  // current conditioning
  // ****************************************************
  logic [CUR_W-1:0] imax;
  logic [CUR_W-1:0] full_load_current;
  assign imax = max3(phase_a_i, phase_b_i, phase_c_i);
  assign full_load_current = full_load_current_i;

  // ****************************************************
  // running qualifier
  // ****************************************************
  logic [TMR_W-1:0] run_cnt_ff;
  logic running_ff;
  logic in_run_win;

  assign in_run_win = pct_ge(imax, full_load_current, RUN_LO_PCT)
    && (32'(imax) * 32'd100 <= 32'(full_load_current) * 32'(RUN_HI_PCT));

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      run_cnt_ff <= '0;
    end
    else if (tick)
    begin
      if (!in_run_win)
      begin
        run_cnt_ff <= '0;
      end
      else if (run_cnt_ff != RUN_TICKS)
      begin
        run_cnt_ff <= run_cnt_ff + 1'b1;
      end
    end
  end

  // a stopped motor drops the qualifier; overload above the window keeps it
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      running_ff <= 1'b0;
    end
    else if (tick)
    begin
      if (!pct_ge(imax, full_load_current, RUN_LO_PCT))
      begin
        running_ff <= 1'b0;
      end
      else if (in_run_win && run_cnt_ff == RUN_TICKS)
      begin
        running_ff <= 1'b1;
      end
    end
  end

  // ****************************************************
  // thermal model
  // ****************************************************
  logic [SF_W-1:0] sf_eff;
  logic [6:0] sfp;
  logic [CLS_W-1:0] cls_eff;
  logic th_en;
  logic th_alm_en;
  logic [23:0] ult;
  logic [71:0] fin_num;
  logic [71:0] fin_den;
  logic [71:0] fin_quo;
  logic [ACC_W-1:0] fin;
  logic signed [63:0] step;
  logic signed [63:0] sum;
  logic [ACC_W-1:0] nxt_acc;
  logic [ACC_W-1:0] acc_ff;

  assign sf_eff = (sf_code_i > SF_CODE_MAX) ? SF_CODE_MAX : sf_code_i;
  assign sfp = SF_BASE_PCT + 7'(sf_eff);
  assign th_en = (class_trip_i != CLS_DEL) && (class_trip_i >= CLS_MIN);
  assign th_alm_en = th_en && (class_alarm_i != CLS_DEL) && (class_alarm_i >= CLS_MIN);
  // a deleted class still needs a time constant to keep tracking heat
  assign cls_eff = (!th_en || class_trip_i > CLS_MAX) ? CLS_MAX : class_trip_i;
  assign ult = 24'(32'(full_load_current) * 32'(sfp));

  // final value = (imax / ultimate)^2 of full level
  always_comb
  begin
    fin_num = (72'(imax) * 72'(imax) * 72'(PCT_SQ)) << ACC_FRAC;
    fin_den = 72'(ult) * 72'(ult);
    fin_quo = (fin_den == '0) ? '1 : fin_num / fin_den;
    fin = (fin_quo > 72'(ACC_MAX)) ? ACC_MAX : fin_quo[ACC_W-1:0];
  end

  // tau = class * 36 / sf^2 seconds, so trip time at six times
  // full-load current is close to the class value from cold
  always_comb
  begin
    step = ($signed(64'(fin)) - $signed(64'(acc_ff))) * $signed(64'(32'(sfp) * 32'(sfp)))
         / $signed(64'(CLASS_MULT_SQ * PCT_SQ) * 64'(cls_eff) * 64'(TPS));
    sum = $signed(64'(acc_ff)) + step;
    if (sum < 0)
    begin
      nxt_acc = '0;
    end
    else if (sum > $signed(64'(ACC_MAX)))
    begin
      nxt_acc = ACC_MAX;
    end
    else
    begin
      nxt_acc = sum[ACC_W-1:0];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      acc_ff <= '0;
    end
    else if (tick)
    begin
      acc_ff <= nxt_acc;
    end
  end

  // ****************************************************
  // thermal trip and alarm
  // ****************************************************
  logic th_trip_ff;
  logic th_alm_ff;
  logic th_trip_set;
  logic th_alm_cond;

  assign th_trip_set = th_en && (acc_ff >= ACC_FULL);
  assign th_alm_cond = th_alm_en
    && (40'(acc_ff) * 40'(class_trip_i) >= 40'(ACC_FULL) * 40'(class_alarm_i));

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      th_trip_ff <= 1'b0;
    end
    else if (th_trip_set)
    begin
      th_trip_ff <= 1'b1;
    end
    else if (acc_ff <= ACC_RST && (autoreset_i || reset_req))
    begin
      th_trip_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      th_alm_ff <= 1'b0;
    end
    else if (th_alm_cond)
    begin
      th_alm_ff <= 1'b1;
    end
    else if (!alarm_latch_i || reset_req || !th_alm_en)
    begin
      th_alm_ff <= 1'b0;
    end
  end

  // ****************************************************
  // short-circuit trip
  // ****************************************************
  // not qualified by running and not tied to the jam set point
  logic sc_ff;

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      sc_ff <= 1'b0;
    end
    else if (sc_en_i && pct_ge(imax, full_load_current, SC_PCT))
    begin
      sc_ff <= 1'b1;
    end
    else if (reset_req)
    begin
      sc_ff <= 1'b0;
    end
  end

  // ****************************************************
  // jam and loss-of-load timed functions
  // ****************************************************
  logic [NT-1:0] set_c;
  logic [NT-1:0] hold_c;
  logic [NT-1:0] en_c;
  logic [NT-1:0] flag_ff;

  assign en_c[0] = running_ff && !is_del(oc_trip_sp_i);
  assign en_c[1] = running_ff && !is_del(oc_alarm_sp_i);
  assign en_c[2] = running_ff && !is_del(uc_trip_sp_i);
  assign en_c[3] = running_ff && !is_del(uc_alarm_sp_i);

  assign set_c[0] = en_c[0] && pct_ge(imax, full_load_current, oc_trip_sp_i);
  assign set_c[1] = en_c[1] && pct_ge(imax, full_load_current, oc_alarm_sp_i);
  assign set_c[2] = en_c[2] && !pct_ge(imax, full_load_current, uc_trip_sp_i);
  assign set_c[3] = en_c[3] && !pct_ge(imax, full_load_current, uc_alarm_sp_i);

  // alarm hysteresis: the condition must clear past the band before release
  assign hold_c[0] = 1'b0;
  assign hold_c[1] = en_c[1] && pct_ge(imax, full_load_current, oc_alarm_sp_i - OC_HYST_PCT);
  assign hold_c[2] = 1'b0;
  assign hold_c[3] = en_c[3] && !pct_ge(imax, full_load_current, uc_alarm_sp_i + UC_HYST_PCT);

  for (genvar g = 0; g < NT; g++)
  begin : g_tmr
    logic [TMR_W-1:0] tmr_ff;
    logic fire;

    assign fire = tick && set_c[g] && (tmr_ff >= TMR_LIM[g] - 1'b1);

    always_ff @(posedge clk_i)
    begin
      if (sys_rst_i || !set_c[g])
      begin
        tmr_ff <= '0;
      end
      else if (tick && tmr_ff < TMR_LIM[g] - 1'b1)
      begin
        tmr_ff <= tmr_ff + 1'b1;
      end
    end

    // even entries are trips, odd ones alarms; a firing event beats any clear
    always_ff @(posedge clk_i)
    begin
      if (sys_rst_i)
      begin
        flag_ff[g] <= 1'b0;
      end
      else if (fire)
      begin
        flag_ff[g] <= 1'b1;
      end
      else if (g % 2 == 0)
      begin
        if (reset_req)
        begin
          flag_ff[g] <= 1'b0;
        end
      end
      else if (!hold_c[g] && (!alarm_latch_i || reset_req))
      begin
        flag_ff[g] <= 1'b0;
      end
    end
  end

  // ****************************************************
  // outputs
  // ****************************************************
  assign thermal_accumulator_o = acc_ff;
  assign thermal_trip_o = th_trip_ff;
  assign thermal_alarm_o = th_alm_ff;
  assign sc_trip_o = sc_ff;
  assign oc_trip_o = flag_ff[0];
  assign oc_alarm_o = flag_ff[1];
  assign uc_trip_o = flag_ff[2];
  assign uc_alarm_o = flag_ff[3];
  assign running_o = running_ff;

endmodule

/* File: mop_pkg.sv */
// constants for the motor overload protection logic
package mop_pkg;

  // ****************************************************
  // widths
  // ****************************************************
  localparam int CUR_W = 16;
  localparam int SP_W = 11;
  localparam int CLS_W = 6;
  localparam int SF_W = 5;
  localparam int ACC_W = 32;
  localparam int TMR_W = 12;

  // ****************************************************
  // set point codes
  // ****************************************************
  // all ones in a set point field means the function is deleted
  localparam logic [SP_W-1:0] SP_DEL = 11'h7ff;
  localparam logic [CLS_W-1:0] CLS_DEL = 6'h3f;
  localparam logic [CLS_W-1:0] CLS_MIN = 6'h01;
  localparam logic [CLS_W-1:0] CLS_MAX = 6'h2d;
  localparam logic [SF_W-1:0] SF_CODE_MAX = 5'h19;
  localparam logic [6:0] SF_BASE_PCT = 7'h64;

  // ****************************************************
  // current levels in percent of full-load current
  // ****************************************************
  localparam logic [SP_W-1:0] RUN_LO_PCT = 11'h00a;
  localparam logic [SP_W-1:0] RUN_HI_PCT = 11'h07d;
  localparam logic [SP_W-1:0] SC_PCT = 11'h4b0;
  localparam logic [SP_W-1:0] OC_HYST_PCT = 11'h005;
  localparam logic [SP_W-1:0] UC_HYST_PCT = 11'h002;

  // ****************************************************
  // thermal accumulator scaling
  // ****************************************************
  localparam int ACC_FRAC = 24;
  localparam logic [ACC_W-1:0] ACC_FULL = 32'h0100_0000;
  localparam logic [ACC_W-1:0] ACC_MAX = 32'hffff_ffff;
  localparam int ACC_RST_PCT = 30;
  localparam logic [ACC_W-1:0] ACC_RST = ACC_W'(64'(ACC_FULL) * ACC_RST_PCT / 100);
  localparam int PCT_SQ = 10000;
  localparam int CLASS_MULT_SQ = 36;

  // ****************************************************
  // timing
  // ****************************************************
  localparam int CLK_MHZ = 250;
  localparam int TICK_MS = 10;
  localparam int TICK_CYC = CLK_MHZ * 1000 * TICK_MS;
  localparam int TPS = 1000 / TICK_MS;
  localparam int RUN_S = 10;
  localparam int OC_MS = 250;
  localparam int UC_TRIP_S = 5;
  localparam int UC_ALM_S = 1;
  localparam logic [TMR_W-1:0] RUN_TICKS = TMR_W'(RUN_S * TPS);
  // timed functions: 0 jam trip, 1 jam alarm, 2 loss-of-load trip, 3 loss-of-load alarm
  localparam int NT = 4;
  localparam logic [TMR_W-1:0] TMR_LIM [NT] = '{
    TMR_W'(OC_MS / TICK_MS),
    TMR_W'(OC_MS / TICK_MS),
    TMR_W'(UC_TRIP_S * TPS),
    TMR_W'(UC_ALM_S * TPS)
  };

endpackage

/* File: mop_tick.sv */
// periodic tick generator for the protection timers
`timescale 1ns/1ns
module mop_tick #(
  parameter int CYC = mop_pkg::TICK_CYC
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  output logic tick_o
);

  localparam int CW = $clog2(CYC);

  logic [CW-1:0] cnt_ff;

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i || cnt_ff == CW'(CYC - 1))
    begin
      cnt_ff <= '0;
    end
    else
    begin
      cnt_ff <= cnt_ff + 1'b1;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      tick_o <= 1'b0;
    end
    else
    begin
      tick_o <= (cnt_ff == CW'(CYC - 1));
    end
  end

endmodule

/* File: mop_properties.sv */
// port-level checks for the motor overload protection top
`timescale 1ns/1ns
module mop_properties #(
  parameter int TICK_CYCLES = 10
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [mop_pkg::CUR_W-1:0] phase_a_i,
  input wire logic [mop_pkg::CUR_W-1:0] phase_b_i,
  input wire logic [mop_pkg::CUR_W-1:0] phase_c_i,
  input wire logic [mop_pkg::CUR_W-1:0] full_load_current_i,
  input wire logic [mop_pkg::CLS_W-1:0] class_trip_i,
  input wire logic [mop_pkg::CLS_W-1:0] class_alarm_i,
  input wire logic [mop_pkg::SP_W-1:0] oc_trip_sp_i,
  input wire logic [mop_pkg::SP_W-1:0] uc_trip_sp_i,
  input wire logic sc_en_i,
  input wire logic alarm_latch_i,
  input wire logic [mop_pkg::ACC_W-1:0] thermal_accumulator_o,
  input wire logic thermal_trip_o,
  input wire logic thermal_alarm_o,
  input wire logic oc_trip_o,
  input wire logic oc_alarm_o,
  input wire logic sc_trip_o,
  input wire logic uc_trip_o,
  input wire logic uc_alarm_o,
  input wire logic running_o
);
  import mop_pkg::*;
  // ****************************************************
  // current levels scaled by one hundred
  // ****************************************************
  logic [CUR_W-1:0] imax;
  logic [31:0] p100;
  logic [31:0] full_load_current;
  logic cls_ok;
  logic alm_hit;
  logic in_win;
  logic oc_hi;
  logic uc_lo;
  logic sc_hit;
  always_comb
  begin
    imax = (phase_a_i > phase_b_i) ? phase_a_i : phase_b_i;
    if (phase_c_i > imax)
      imax = phase_c_i;
  end
  assign full_load_current = 32'(full_load_current_i);
  assign p100 = 32'(imax) * 32'(SF_BASE_PCT);
  assign in_win = p100 >= full_load_current * 32'(RUN_LO_PCT) && p100 <= full_load_current * 32'(RUN_HI_PCT);
  assign oc_hi = p100 >= full_load_current * 32'(oc_trip_sp_i);
  assign uc_lo = p100 < full_load_current * 32'(uc_trip_sp_i);
  assign sc_hit = sc_en_i && p100 >= full_load_current * 32'(SC_PCT);
  assign cls_ok = class_trip_i != CLS_DEL && class_trip_i != '0;
  // 64 bits: accumulator times class overflows 32
  assign alm_hit = cls_ok && class_alarm_i != CLS_DEL && class_alarm_i != '0 &&
    64'(thermal_accumulator_o) * 64'(class_trip_i) >= 64'(ACC_FULL) * 64'(class_alarm_i);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);
  rst_clear_a: assert property (
    $fell(sys_rst_i) |-> thermal_accumulator_o == '0 && !(thermal_trip_o | thermal_alarm_o |
    oc_trip_o | oc_alarm_o | sc_trip_o | uc_trip_o | uc_alarm_o | running_o))
    else $error("outputs not cleared by reset");
  sc_fast_a: assert property (sc_hit |=> sc_trip_o)
    else $error("short-circuit trip late");
  therm_full_a: assert property (
    thermal_accumulator_o >= ACC_FULL && cls_ok |=> thermal_trip_o)
    else $error("thermal trip missing at full level");
  therm_hold_a: assert property (
    thermal_trip_o && thermal_accumulator_o > ACC_RST |=> thermal_trip_o)
    else $error("thermal trip cleared above reset level");
  therm_alarm_a: assert property (alm_hit |=> thermal_alarm_o)
    else $error("thermal alarm missing");
  alarm_del_a: assert property (
    (class_trip_i == CLS_DEL && !alarm_latch_i) [*2] |-> !thermal_alarm_o)
    else $error("thermal alarm with trip deleted");
  jam_gate_a: assert property (
    $rose(oc_trip_o) || $rose(oc_alarm_o) |-> $past(running_o))
    else $error("jam flag while not running");
  jam_level_a: assert property ($rose(oc_trip_o) |-> $past(oc_hi))
    else $error("jam trip below set point");
  uc_gate_a: assert property ($rose(uc_trip_o) || $rose(uc_alarm_o) |-> $past(running_o))
    else $error("loss-of-load flag while not running");
  uc_below_a: assert property ($rose(uc_trip_o) |-> $past(uc_lo))
    else $error("loss-of-load trip above set point");
  run_win_a: assert property ($rose(running_o) |-> $past(in_win))
    else $error("running set outside window");
endmodule
bind mop_top mop_properties #(.TICK_CYCLES(TICK_CYCLES)) u_props (
  .clk_i, .sys_rst_i, .phase_a_i, .phase_b_i, .phase_c_i, .full_load_current_i,
  .class_trip_i, .class_alarm_i, .oc_trip_sp_i, .uc_trip_sp_i, .sc_en_i, .alarm_latch_i,
  .thermal_accumulator_o, .thermal_trip_o, .thermal_alarm_o, .oc_trip_o, .oc_alarm_o,
  .sc_trip_o, .uc_trip_o, .uc_alarm_o, .running_o
);

/* File: mop_phase_src.sv */
// phase current front end: one peak phase, the other two at three quarters
`timescale 1ns/1ns
module mop_phase_src (
  input wire logic [mop_pkg::CUR_W-1:0] level_i,
  input wire logic [1:0] peak_sel_i,
  output logic [mop_pkg::CUR_W-1:0] phase_a_o,
  output logic [mop_pkg::CUR_W-1:0] phase_b_o,
  output logic [mop_pkg::CUR_W-1:0] phase_c_o
);
  import mop_pkg::*;
  // ****************************************************
  // unbalanced magnitudes
  // ****************************************************
  // lower phases differ from the peak so a wrong phase pick shows up
  logic [CUR_W-1:0] low;
  assign low = level_i - (level_i >> 2);
  assign phase_a_o = (peak_sel_i == 2'h0) ? level_i : low;
  assign phase_b_o = (peak_sel_i == 2'h1) ? level_i : low;
  assign phase_c_o = (peak_sel_i == 2'h2) ? level_i : low;
endmodule

/* File: mop_top_test.sv */
// self-checking bench for the motor overload protection top
`timescale 1ns/1ns
module mop_top_test;
  import mop_pkg::*;
  // ****************************************************
  // stimulus and wiring
  // ****************************************************
  localparam int TC = 10;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [CUR_W-1:0] lvl = '0;
  logic [1:0] sel = 2'h0;
  logic [CUR_W-1:0] full_load_current = 16'h0064;
  logic [SF_W-1:0] sf = '0;
  logic [CLS_W-1:0] ct = 6'h0a;
  logic [CLS_W-1:0] ca = 6'h09;
  logic [SP_W-1:0] ots = 11'h12c;
  logic [SP_W-1:0] oas = 11'h0c8;
  logic [SP_W-1:0] uts = SP_DEL;
  logic [SP_W-1:0] uas = SP_DEL;
  logic sc_en = 1'b1;
  logic ar = 1'b0;
  logic al = 1'b0;
  logic rb = 1'b0;
  logic [CUR_W-1:0] pa, pb, pc;
  logic [ACC_W-1:0] acc;
  logic [7:0] fl;
  int mismatches = 0;
  int checks_done = 0;
  always #2 clk_i = ~clk_i;
  mop_phase_src u_src (.level_i(lvl), .peak_sel_i(sel), .phase_a_o(pa), .phase_b_o(pb),
    .phase_c_o(pc));
  mop_top #(.TICK_CYCLES(TC)) dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .phase_a_i(pa),
    .phase_b_i(pb), .phase_c_i(pc), .full_load_current_i(full_load_current), .sf_code_i(sf),
    .class_trip_i(ct), .class_alarm_i(ca), .oc_trip_sp_i(ots), .oc_alarm_sp_i(oas),
    .uc_trip_sp_i(uts), .uc_alarm_sp_i(uas), .sc_en_i(sc_en), .autoreset_i(ar),
    .alarm_latch_i(al), .reset_btn_i(rb), .thermal_accumulator_o(acc),
    .thermal_trip_o(fl[0]), .thermal_alarm_o(fl[1]), .oc_trip_o(fl[2]), .oc_alarm_o(fl[3]),
    .sc_trip_o(fl[4]), .uc_trip_o(fl[5]), .uc_alarm_o(fl[6]), .running_o(fl[7]));
  // ****************************************************
  // tasks
  // ****************************************************
  task automatic end_of_test();
    if (mismatches == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk1(input logic got, input logic exp);
    checks_done++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chkw(input logic [ACC_W-1:0] got, input logic [ACC_W-1:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // flag index: 0 thermal trip .. 7 running; overrun ends the run
  task automatic wait_fl(input int idx, input logic v, input int lim, output int n);
    n = 0;
    while (fl[idx] !== v)
    begin
      @(negedge clk_i);
      n++;
      if (n > lim)
      begin
        mismatches++;
        $display("BAD %0t got %h exp %h", $time, fl[idx], v);
        end_of_test();
      end
    end
  endtask
  task automatic press_reset();
    @(negedge clk_i);
    rb = 1'b1;
    repeat (4) @(negedge clk_i);
    rb = 1'b0;
  endtask
  // ****************************************************
  // sequence
  // ****************************************************
  initial
  begin
    int n;
    repeat (16) @(negedge clk_i);
    sys_rst_i = 1'b0;
    chkw(acc, '0);
    chk1(|fl, 1'b0);
    lvl = 16'h04af;
    sel = 2'h2;
    repeat (20) @(negedge clk_i);
    chk1(fl[4], 1'b0);
    lvl = 16'h04b0;
    wait_fl(4, 1'b1, 3, n);
    chk1(fl[7], 1'b0);
    lvl = '0;
    repeat (20) @(negedge clk_i);
    chk1(fl[4], 1'b1);
    press_reset();
    wait_fl(4, 1'b0, 3, n);
    lvl = 16'h005a;
    sel = 2'h1;
    wait_fl(7, 1'b1, 10100, n);
    chk1(n >= 9990 && n <= 10020, 1'b1);
    lvl = 16'h0136;
    wait_fl(2, 1'b1, 300, n);
    chk1(n >= 235 && n <= 262, 1'b1);
    chk1(fl[3], 1'b1);
    lvl = 16'h005a;
    wait_fl(3, 1'b0, 3, n);
    repeat (30) @(negedge clk_i);
    chk1(fl[2], 1'b1);
    press_reset();
    wait_fl(2, 1'b0, 3, n);
    ots = SP_DEL;
    lvl = 16'h0136;
    repeat (300) @(negedge clk_i);
    chk1(fl[2], 1'b0);
    chk1(fl[3], 1'b1);
    lvl = 16'h04b0;
    wait_fl(4, 1'b1, 3, n);
    uts = 11'h028;
    uas = 11'h032;
    lvl = 16'h001e;
    wait_fl(6, 1'b1, 1100, n);
    chk1(n >= 985 && n <= 1012, 1'b1);
    chk1(fl[5], 1'b0);
    wait_fl(5, 1'b1, 4100, n);
    chk1(n >= 3980, 1'b1);
    al = 1'b1;
    lvl = 16'h005a;
    repeat (10) @(negedge clk_i);
    chk1(fl[6], 1'b1);
    press_reset();
    wait_fl(6, 1'b0, 3, n);
    wait_fl(5, 1'b0, 3, n);
    al = 1'b0;
    uts = SP_DEL;
    uas = SP_DEL;
    ct = 6'h02;
    ca = 6'h01;
    lvl = 16'h0258;
    wait_fl(1, 1'b1, 3000, n);
    chk1(acc >= 32'h0080_0000 && acc < ACC_FULL, 1'b1);
    chk1(fl[0], 1'b0);
    wait_fl(0, 1'b1, 3000, n);
    chk1(acc >= ACC_FULL, 1'b1);
    lvl = '0;
    ct = 6'h01;
    ca = CLS_DEL;
    ar = 1'b1;
    press_reset();
    chk1(fl[0], 1'b1);
    wait_fl(0, 1'b0, 60000, n);
    chk1(acc <= ACC_RST, 1'b1);
    ct = CLS_DEL;
    ca = 6'h01;
    lvl = 16'h0258;
    repeat (300) @(negedge clk_i);
    chk1(fl[1] | fl[0], 1'b0);
    end_of_test();
  end
endmodule
